/* jfa_defines.svh */
`ifndef JFA_DEFINES_SVH
`define JFA_DEFINES_SVH
// Summary of operation
// - One 16-bit address register locates every host flash read, program and erase.
// - Address increments by one after each read or program, pass or fail.
// - Data/status register is 10 bits, resets to zero, byte in bits 9:2.
// - Bit 1 is the fail flag of the previous flash operation.
// - Bit 0 is the busy flag, high while a request is processed.
// - The last register read or write issued while busy is held and run at the next capture that reads busy low.
// - Watchdog is held disabled while the processor is halted.
// - Peripherals keep running and stay synchronized during debug activity.
// - Control bit 7 steers host flash accesses to the scratchpad sector.
// - Write mode 001 programs the byte; mode 010 erases the page on 0xA5.
// - Read mode 0001 reads when idle; 0010 also needs the last byte collected.
// - Results return busy in bit 0, read data right-justified in 18:1.

// ------------------------------------------------------------
// Instruction codes
// ------------------------------------------------------------
`define JFA_IR_W 4
`define JFA_IR_CTRL 4'h4
`define JFA_IR_DATA 4'h5
`define JFA_IR_ADDR 4'h6
`define JFA_IR_BYPASS 4'hF
`define JFA_IR_CAPTURE 4'h1

// ------------------------------------------------------------
// Indirect command fields
// ------------------------------------------------------------
`define JFA_DR_W 20
`define JFA_OP_VALID_BIT 19
`define JFA_OP_WRITE_BIT 18
`define JFA_WDATA_W 18
`define JFA_BYTE_HI 17
`define JFA_BYTE_LO 10
`define JFA_ADDR_HI 17
`define JFA_ADDR_LO 2

// ------------------------------------------------------------
// Control register fields and modes
// ------------------------------------------------------------
`define JFA_CTRL_RST 8'h00
`define JFA_CTRL_SCRATCH_BIT 7
`define JFA_WRMD_HI 6
`define JFA_WRMD_LO 4
`define JFA_RDMD_HI 3
`define JFA_RDMD_LO 0
`define JFA_WRMD_PROGRAM 3'h1
`define JFA_WRMD_ERASE 3'h2
`define JFA_RDMD_BLOCK 4'h1
`define JFA_RDMD_SINGLE 4'h2
`define JFA_ERASE_KEY 8'hA5

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define JFA_ADDR_RST 16'h0000
`define JFA_BYTE_RST 8'h00
`endif

/* jfa_pkg.sv */
package jfa_pkg;
	typedef enum logic [3:0] {
		TAP_RESET = 4'h0, TAP_IDLE = 4'h1, TAP_SEL_DR = 4'h2, TAP_CAP_DR = 4'h3,
		TAP_SHIFT_DR = 4'h4, TAP_EXIT1_DR = 4'h5, TAP_PAUSE_DR = 4'h6,
		TAP_EXIT2_DR = 4'h7, TAP_UPD_DR = 4'h8, TAP_SEL_IR = 4'h9,
		TAP_CAP_IR = 4'hA, TAP_SHIFT_IR = 4'hB, TAP_EXIT1_IR = 4'hC,
		TAP_PAUSE_IR = 4'hD, TAP_EXIT2_IR = 4'hE, TAP_UPD_IR = 4'hF
	} tap_state_t;

	typedef enum logic [1:0] {
		FL_READ = 2'h0,
		FL_PROGRAM = 2'h1,
		FL_ERASE = 2'h2
	} flash_op_t;

	typedef struct packed {
		flash_op_t op;
		logic scratch_sector_select;
		logic [15:0] addr;
		logic [7:0] wdata;
	} flash_req_t;
endpackage : jfa_pkg

/* jfa_pin_filter.sv */
`timescale 1ns/100ps
module jfa_pin_filter #(
	parameter int WIDTH = 3
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] pin_in,
	output logic [WIDTH-1:0] level
);
	logic [WIDTH-1:0] s1_ff;
	logic [WIDTH-1:0] s2_ff;
	logic [WIDTH-1:0] s3_ff;
	logic [WIDTH-1:0] level_ff;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_ff <= '0;
			s2_ff <= '0;
			s3_ff <= '0;
		end else begin
			s1_ff <= pin_in;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
		end
	end

	// A change counts once stages two and three agree
	genvar i;
	for (i = 0; i < WIDTH; i++) begin : g_bit
		always_ff @(posedge clk or negedge rst_n) begin
			if (!rst_n)
				level_ff[i] <= 1'b0;
			else if (s2_ff[i] == s3_ff[i])
				level_ff[i] <= s3_ff[i];
		end
	end

	assign level = level_ff;
endmodule : jfa_pin_filter

/* jtag_flash_access_port.sv */
`timescale 1ns/100ps
`include "jfa_defines.svh"
module jtag_flash_access_port
	import jfa_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi,
	output logic tdo,
	output logic tdo_oe,
	output logic fl_valid,
	output flash_req_t fl_req,
	input wire logic fl_done,
	input wire logic fl_fail,
	input wire logic [7:0] fl_rdata,
	input wire logic cpu_halted,
	output logic supervisory_timer_hold,
	output logic periph_run
);
	// ------------------------------------------------------------
	// Reset release
	// ------------------------------------------------------------
	logic [1:0] rst_pipe_ff;
	logic rst_sync_n;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			rst_pipe_ff <= 2'h0;
		else
			rst_pipe_ff <= {rst_pipe_ff[0], 1'b1};
	end
	assign rst_sync_n = rst_pipe_ff[1];

	// ------------------------------------------------------------
	// Pin sampling
	// ------------------------------------------------------------
	logic [2:0] pin_lvl;
	logic tck_prev_ff;
	logic tck_rise;
	logic tck_fall;
	logic tms_lvl;
	logic tdi_lvl;

	jfa_pin_filter #(.WIDTH(3)) u_pin_filter (
		.clk(clk),
		.rst_n(rst_sync_n),
		.pin_in({tck, tms, tdi}),
		.level(pin_lvl)
	);

	assign tms_lvl = pin_lvl[1];
	assign tdi_lvl = pin_lvl[0];
	assign tck_rise = pin_lvl[2] & ~tck_prev_ff;
	assign tck_fall = ~pin_lvl[2] & tck_prev_ff;

	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n)
			tck_prev_ff <= 1'b0;
		else
			tck_prev_ff <= pin_lvl[2];
	end

	// ------------------------------------------------------------
	// Test access state machine
	// ------------------------------------------------------------
	tap_state_t tap_state_ff;
	tap_state_t nxt_tap_state;

	always_comb begin
		unique case (tap_state_ff)
			TAP_RESET: nxt_tap_state = tms_lvl ? TAP_RESET : TAP_IDLE;
			TAP_IDLE: nxt_tap_state = tms_lvl ? TAP_SEL_DR : TAP_IDLE;
			TAP_SEL_DR: nxt_tap_state = tms_lvl ? TAP_SEL_IR : TAP_CAP_DR;
			TAP_CAP_DR: nxt_tap_state = tms_lvl ? TAP_EXIT1_DR : TAP_SHIFT_DR;
			TAP_SHIFT_DR: nxt_tap_state = tms_lvl ? TAP_EXIT1_DR : TAP_SHIFT_DR;
			TAP_EXIT1_DR: nxt_tap_state = tms_lvl ? TAP_UPD_DR : TAP_PAUSE_DR;
			TAP_PAUSE_DR: nxt_tap_state = tms_lvl ? TAP_EXIT2_DR : TAP_PAUSE_DR;
			TAP_EXIT2_DR: nxt_tap_state = tms_lvl ? TAP_UPD_DR : TAP_SHIFT_DR;
			TAP_UPD_DR: nxt_tap_state = tms_lvl ? TAP_SEL_DR : TAP_IDLE;
			TAP_SEL_IR: nxt_tap_state = tms_lvl ? TAP_RESET : TAP_CAP_IR;
			TAP_CAP_IR: nxt_tap_state = tms_lvl ? TAP_EXIT1_IR : TAP_SHIFT_IR;
			TAP_SHIFT_IR: nxt_tap_state = tms_lvl ? TAP_EXIT1_IR : TAP_SHIFT_IR;
			TAP_EXIT1_IR: nxt_tap_state = tms_lvl ? TAP_UPD_IR : TAP_PAUSE_IR;
			TAP_PAUSE_IR: nxt_tap_state = tms_lvl ? TAP_EXIT2_IR : TAP_PAUSE_IR;
			TAP_EXIT2_IR: nxt_tap_state = tms_lvl ? TAP_UPD_IR : TAP_SHIFT_IR;
			TAP_UPD_IR: nxt_tap_state = tms_lvl ? TAP_SEL_DR : TAP_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n)
			tap_state_ff <= TAP_RESET;
		else if (tck_rise)
			tap_state_ff <= nxt_tap_state;
	end

	// ------------------------------------------------------------
	// Instruction and data shift paths
	// ------------------------------------------------------------
	logic [`JFA_IR_W-1:0] ir_sh_ff;
	logic [`JFA_IR_W-1:0] ir_ff;
	logic [`JFA_DR_W-1:0] dr_sh_ff;
	logic [`JFA_WDATA_W-1:0] rd_result_ff;
	logic busy_ff;
	logic ind_sel;
	logic cap_dr;
	logic upd_dr;

	assign ind_sel = (ir_ff == `JFA_IR_CTRL) || (ir_ff == `JFA_IR_DATA)
		|| (ir_ff == `JFA_IR_ADDR);
	assign cap_dr = tck_rise && (tap_state_ff == TAP_CAP_DR) && ind_sel;
	// Poll (0x) never updates; only 1x carries a read or write
	assign upd_dr = tck_rise && (tap_state_ff == TAP_UPD_DR) && ind_sel
		&& dr_sh_ff[`JFA_OP_VALID_BIT];

	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			ir_sh_ff <= '0;
			ir_ff <= `JFA_IR_BYPASS;
		end else if (tck_rise) begin
			unique case (tap_state_ff)
				TAP_RESET: ir_ff <= `JFA_IR_BYPASS;
				TAP_CAP_IR: ir_sh_ff <= `JFA_IR_CAPTURE;
				TAP_SHIFT_IR: ir_sh_ff <= {tdi_lvl, ir_sh_ff[`JFA_IR_W-1:1]};
				TAP_UPD_IR: ir_ff <= ir_sh_ff;
				default: ir_ff <= ir_ff;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n)
			dr_sh_ff <= '0;
		else if (tck_rise && tap_state_ff == TAP_CAP_DR)
			dr_sh_ff <= ind_sel ? {1'b0, rd_result_ff, busy_ff} : '0;
		else if (tck_rise && tap_state_ff == TAP_SHIFT_DR)
			dr_sh_ff <= ind_sel ? {tdi_lvl, dr_sh_ff[`JFA_DR_W-1:1]}
				: {{(`JFA_DR_W-1){1'b0}}, tdi_lvl};
	end

	logic tdo_ff;
	logic tdo_oe_ff;

	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			tdo_ff <= 1'b0;
			tdo_oe_ff <= 1'b0;
		end else if (tck_fall) begin
			tdo_ff <= (tap_state_ff == TAP_SHIFT_IR) ? ir_sh_ff[0] : dr_sh_ff[0];
			tdo_oe_ff <= (tap_state_ff == TAP_SHIFT_IR) || (tap_state_ff == TAP_SHIFT_DR);
		end
	end

	// ------------------------------------------------------------
	// Command queueing while busy
	// ------------------------------------------------------------
	logic pend_ff;
	logic pend_wr_ff;
	logic [`JFA_IR_W-1:0] pend_ir_ff;
	logic [`JFA_WDATA_W-1:0] pend_data_ff;
	logic go;
	logic go_wr;
	logic [`JFA_IR_W-1:0] go_ir;
	logic [`JFA_WDATA_W-1:0] go_data;
	logic [7:0] go_byte;

	// Commands held off while busy launch at the capture that reads busy low
	assign go = !busy_ff && (upd_dr || (cap_dr && pend_ff));
	assign go_wr = upd_dr ? dr_sh_ff[`JFA_OP_WRITE_BIT] : pend_wr_ff;
	assign go_ir = upd_dr ? ir_ff : pend_ir_ff;
	assign go_data = upd_dr ? dr_sh_ff[`JFA_WDATA_W-1:0] : pend_data_ff;
	assign go_byte = go_data[`JFA_BYTE_HI:`JFA_BYTE_LO];

	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			pend_ff <= 1'b0;
			pend_wr_ff <= 1'b0;
			pend_ir_ff <= '0;
			pend_data_ff <= '0;
		end else if (upd_dr && busy_ff) begin
			pend_ff <= 1'b1;
			pend_wr_ff <= dr_sh_ff[`JFA_OP_WRITE_BIT];
			pend_ir_ff <= ir_ff;
			pend_data_ff <= dr_sh_ff[`JFA_WDATA_W-1:0];
		end else if (go) begin
			pend_ff <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Flash registers and sequencer
	// ------------------------------------------------------------
	logic [7:0] nvm_access_control_ff;
	logic [15:0] flash_target_pointer_ff;
	logic [7:0] data_byte_ff;
	logic fail_ff;
	logic collected_ff;
	flash_op_t cur_op_ff;
	logic fl_valid_ff;
	flash_req_t fl_req_ff;
	logic [2:0] write_action_select;
	logic [3:0] read_action_select;
	logic start;
	flash_op_t start_op;

	assign write_action_select = nvm_access_control_ff[`JFA_WRMD_HI:`JFA_WRMD_LO];
	assign read_action_select = nvm_access_control_ff[`JFA_RDMD_HI:`JFA_RDMD_LO];

	always_comb begin
		start = 1'b0;
		start_op = FL_READ;
		if (go && go_ir == `JFA_IR_DATA) begin
			if (go_wr) begin
				if (write_action_select == `JFA_WRMD_PROGRAM) begin
					start = 1'b1;
					start_op = FL_PROGRAM;
				end else if (write_action_select == `JFA_WRMD_ERASE
					&& go_byte == `JFA_ERASE_KEY) begin
					start = 1'b1;
					start_op = FL_ERASE;
				end
			end else begin
				start = (read_action_select == `JFA_RDMD_BLOCK)
					|| (read_action_select == `JFA_RDMD_SINGLE && collected_ff);
			end
		end
	end

	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			nvm_access_control_ff <= `JFA_CTRL_RST;
			flash_target_pointer_ff <= `JFA_ADDR_RST;
			data_byte_ff <= `JFA_BYTE_RST;
			fail_ff <= 1'b0;
			busy_ff <= 1'b0;
			collected_ff <= 1'b1;
			cur_op_ff <= FL_READ;
			rd_result_ff <= '0;
			fl_valid_ff <= 1'b0;
			fl_req_ff <= '0;
		end else begin
			fl_valid_ff <= start;
			if (start) begin
				busy_ff <= 1'b1;
				cur_op_ff <= start_op;
				fl_req_ff.op <= start_op;
				fl_req_ff.scratch_sector_select <=
					nvm_access_control_ff[`JFA_CTRL_SCRATCH_BIT];
				fl_req_ff.addr <= flash_target_pointer_ff;
				fl_req_ff.wdata <= go_byte;
			end else if (busy_ff && fl_done) begin
				busy_ff <= 1'b0;
				fail_ff <= fl_fail;
				if (cur_op_ff == FL_READ) begin
					data_byte_ff <= fl_rdata;
					collected_ff <= 1'b0;
				end
				if (cur_op_ff != FL_ERASE)
					flash_target_pointer_ff <= flash_target_pointer_ff + 16'h0001;
			end
			if (go) begin
				unique case (go_ir)
					`JFA_IR_CTRL: begin
						if (go_wr)
							nvm_access_control_ff <= go_byte;
						else
							rd_result_ff <= {10'h000, nvm_access_control_ff};
					end
					`JFA_IR_ADDR: begin
						if (go_wr)
							flash_target_pointer_ff <= go_data[`JFA_ADDR_HI:`JFA_ADDR_LO];
						else
							rd_result_ff <= {2'h0, flash_target_pointer_ff};
					end
					default: begin
						if (go_wr) begin
							data_byte_ff <= go_byte;
						end else begin
							rd_result_ff <= {8'h00, data_byte_ff, fail_ff, busy_ff};
							collected_ff <= 1'b1;
						end
					end
				endcase
			end
		end
	end

	// ------------------------------------------------------------
	// Debug halt side effects
	// ------------------------------------------------------------
	logic wdt_hold_ff;
	logic periph_run_ff;

	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			wdt_hold_ff <= 1'b0;
			periph_run_ff <= 1'b1;
		end else begin
			wdt_hold_ff <= cpu_halted;
			periph_run_ff <= 1'b1;
		end
	end

	assign tdo = tdo_ff;
	assign tdo_oe = tdo_oe_ff;
	assign fl_valid = fl_valid_ff;
	assign fl_req = fl_req_ff;
	assign supervisory_timer_hold = wdt_hold_ff;
	assign periph_run = periph_run_ff;
endmodule : jtag_flash_access_port

/* jfa_properties.sv */
`timescale 1ns/100ps
`include "jfa_defines.svh"
module jfa_properties
	import jfa_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi,
	input wire logic tdo,
	input wire logic tdo_oe,
	input wire logic fl_valid,
	input flash_req_t fl_req,
	input wire logic fl_done,
	input wire logic fl_fail,
	input wire logic [7:0] fl_rdata,
	input wire logic cpu_halted,
	input wire logic supervisory_timer_hold,
	input wire logic periph_run
);
	logic outst_ff;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) outst_ff <= 1'b0;
		else if (fl_valid) outst_ff <= 1'b1;
		else if (fl_done) outst_ff <= 1'b0;
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	sequence s_launch;
		fl_valid ##1 !fl_valid;
	endsequence
	// Pin fell five samples ago: three sync stages, level and edge flop
	sequence s_tck_fall_seen;
		$past(tck, 6) && !$past(tck, 5);
	endsequence
	property p_pulse; fl_valid |-> s_launch; endproperty
	property p_one_out; fl_valid |-> !outst_ff; endproperty
	property p_done_gap; fl_done && outst_ff |=> !fl_valid; endproperty
	property p_hold; 1'b1 |=> supervisory_timer_hold == $past(cpu_halted); endproperty
	property p_run; periph_run; endproperty
	property p_erase_key;
		fl_valid && fl_req.op == FL_ERASE |-> fl_req.wdata == `JFA_ERASE_KEY;
	endproperty
	property p_req_stable; !fl_valid |-> $stable(fl_req); endproperty
	property p_tdo_edge; $changed(tdo) |-> s_tck_fall_seen; endproperty
	property p_oe_edge; $changed(tdo_oe) |-> s_tck_fall_seen; endproperty

	a_pulse: assert property (p_pulse) else $error("fl_valid not a pulse");
	a_one_out: assert property (p_one_out) else $error("request while busy");
	a_done_gap: assert property (p_done_gap) else $error("request at done");
	a_hold: assert property (p_hold) else $error("timer hold wrong");
	a_run: assert property (p_run) else $error("peripherals stopped");
	a_erase_key: assert property (p_erase_key) else $error("erase without key");
	a_req_stable: assert property (p_req_stable) else $error("fl_req moved");
	a_tdo_edge: assert property (p_tdo_edge) else $error("tdo off edge");
	a_oe_edge: assert property (p_oe_edge) else $error("tdo_oe off edge");
	c_erase: cover property (fl_valid && fl_req.op == FL_ERASE);
endmodule : jfa_properties

/* flash_model.sv */
`timescale 1ns/100ps
module flash_model
	import jfa_pkg::*;
(
	input wire logic clk,
	input wire logic fl_valid,
	input flash_req_t fl_req,
	input wire logic [7:0] lat,
	output logic fl_done,
	output logic fl_fail,
	output logic [7:0] fl_rdata
);
	logic [7:0] mem [logic [16:0]];
	flash_req_t r;
	logic [16:0] k;
	logic bad;

	function automatic logic [7:0] rd(logic [16:0] key);
		return mem.exists(key) ? mem[key] : 8'hFF;
	endfunction : rd

	// Top 4 KB locked; outputs scrambled outside done
	initial begin
		fl_done = 1'b0;
		fl_fail = 1'b0;
		fl_rdata = 8'h00;
		forever begin
			@(posedge clk);
			if (fl_valid === 1'b1) begin
				r = fl_req;
				k = {r.scratch_sector_select, r.addr};
				repeat (lat) @(posedge clk);
				bad = r.addr[15:12] == 4'hF;
				if (r.op == FL_READ) fl_rdata <= rd(k);
				else if (!bad && r.op == FL_PROGRAM) mem[k] = rd(k) & r.wdata;
				else if (!bad) for (int j = 0; j < 512; j++) mem[{k[16:9], j[8:0]}] = 8'hFF;
				fl_fail <= bad;
				fl_done <= 1'b1;
				@(posedge clk);
				fl_done <= 1'b0;
				fl_fail <= !bad;
				fl_rdata <= ~fl_rdata;
			end
		end
	end
endmodule : flash_model

/* tb_top.sv */
`timescale 1ns/100ps
`include "jfa_defines.svh"
module tb_top
	import jfa_pkg::*;
;
	logic clk = 1'b0;
	logic rst_n, tck, tms, tdi, tdo, tdo_oe, fl_valid, fl_done, fl_fail, s, q;
	logic cpu_halted, supervisory_timer_hold, periph_run;
	logic [7:0] fl_rdata, lat, b, exp_b;
	logic [15:0] a, a0, a2, nxt_a;
	logic [19:0] d;
	logic [31:0] seed;
	flash_req_t fl_req;
	flash_req_t req_q[$];
	logic [7:0] ref_mem [logic [16:0]];
	int error_cnt, checked, cyc;

	jtag_flash_access_port i_jtag_flash_access_port (.clk(clk), .rst_n(rst_n), .tck(tck),
		.tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .fl_valid(fl_valid), .fl_req(fl_req),
		.fl_done(fl_done), .fl_fail(fl_fail), .fl_rdata(fl_rdata), .cpu_halted(cpu_halted),
		.supervisory_timer_hold(supervisory_timer_hold), .periph_run(periph_run));
	flash_model i_flash_model (.clk(clk), .fl_valid(fl_valid), .fl_req(fl_req), .lat(lat),
		.fl_done(fl_done), .fl_fail(fl_fail), .fl_rdata(fl_rdata));

	always #12.5 clk = ~clk;

	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (fl_valid === 1'b1) req_q.push_back(fl_req);
		cpu_halted <= cyc > 40 && (cyc[5] ^ cyc[2]);
		if (cyc == 20000) begin
			error_cnt++;
			test_done();
		end
	end

	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs

	function automatic logic [7:0] rref(logic [16:0] key);
		return ref_mem.exists(key) ? ref_mem[key] : 8'hFF;
	endfunction : rref

	task check(input string nm, input logic [26:0] e, input logic [26:0] g);
		checked++;
		if (g !== e) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask : check

	task test_done();
		$display("checks %0d errors %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : test_done

	// ------------------------------------------------------------
	// Test port host
	// ------------------------------------------------------------
	// One 200 ns link clock: low half, then high half; tdo taken before the next fall
	task tbit(input logic m, input logic di, output logic qo);
		tck <= 1'b0;
		tms <= m;
		tdi <= di;
		repeat (4) @(posedge clk);
		tck <= 1'b1;
		repeat (4) @(posedge clk);
		qo = tdo;
	endtask : tbit

	task scan(input logic ir, input int n, input logic [19:0] din, output logic [19:0] dout);
		dout = '0;
		tbit(1'b1, 1'b0, q);
		if (ir) tbit(1'b1, 1'b0, q);
		tbit(1'b0, 1'b0, q);
		tbit(1'b0, 1'b0, q);
		for (int i = 0; i < n; i++) begin
			tbit(i == n - 1, din[i], q);
			dout[i] = q;
			if (i == 0) check("tdo_oe", 1, tdo_oe);
		end
		tbit(1'b1, 1'b0, q);
		tbit(1'b0, 1'b0, q);
		// Let the filtered last rising edge reach the update logic
		repeat (4) @(posedge clk);
	endtask : scan

	task reg_wr(input logic [3:0] ir, input int n, input logic [19:0] v);
		scan(1'b1, 4, {16'h0, ir}, d);
		scan(1'b0, n, v, d);
	endtask : reg_wr

	task reg_rd(input logic [3:0] ir, input int n, output logic [19:0] dout);
		scan(1'b1, 4, {16'h0, ir}, dout);
		scan(1'b0, 2, 20'h2, dout);
		scan(1'b0, n, 20'h0, dout);
	endtask : reg_rd

	task wait_idle();
		for (int i = 0; i < 60; i++) begin
			scan(1'b0, 1, 20'h0, d);
			if (d[0] === 1'b0) return;
		end
		check("busy_clear", 0, 1);
	endtask : wait_idle

	task exp_req(input flash_op_t op, input logic sc, input logic [15:0] ad, input logic [7:0] w);
		flash_req_t r;
		if (req_q.size() == 0) begin
			check("fl_valid", 1, 0);
			return;
		end
		r = req_q.pop_front();
		check("fl_req", {op, sc, ad}, {r.op, r.scratch_sector_select, r.addr});
		if (op != FL_READ) check("fl_wdata", w, r.wdata);
	endtask : exp_req

	task rd_step(input logic go);
		reg_rd(`JFA_IR_DATA, 11, d);
		check("rd_byte", exp_b, d[10:3]);
		if (go) begin
			exp_req(FL_READ, 1'b1, nxt_a, 8'h00);
			wait_idle();
			exp_b = rref({1'b1, nxt_a});
			nxt_a++;
		end else check("no_read", 0, req_q.size());
	endtask : rd_step

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		rst_n = 1'b0;
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b0;
		lat = 8'd3;
		seed = 32'h3911;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		repeat (10) @(posedge clk);
		tbit(1'b0, 1'b0, q);
		scan(1'b1, 4, {16'h0, `JFA_IR_DATA}, d);
		check("ir_capture", 4'h1, d[3:0]);
		reg_rd(`JFA_IR_DATA, 11, d);
		check("data_rst", 0, d[10:0]);
		reg_rd(`JFA_IR_ADDR, 17, d);
		check("addr_rst", 0, d[16:0]);
		$display("test reset done");
		for (int k = 0; k < 3; k++) begin
			a = 16'(xs());
			b = 8'(xs());
			s = k == 2;
			a[15:12] = k == 1 ? 4'hF : 4'h0;
			if (s) a[15:7] = 9'h0;
			if (k == 0) a0 = a;
			a2 = a;
			lat <= k == 0 ? 8'd150 : 8'd3 + b[3:0];
			reg_wr(`JFA_IR_ADDR, 20, {2'b11, a, 2'b00});
			reg_wr(`JFA_IR_CTRL, 10, {2'b11, s, 3'h1, 4'h0});
			reg_wr(`JFA_IR_DATA, 10, {2'b11, b});
			exp_req(FL_PROGRAM, s, a, b);
			scan(1'b0, 1, 20'h0, d);
			if (k == 0) check("busy", 1, d[0]);
			wait_idle();
			if (k != 1) ref_mem[{s, a}] = rref({s, a}) & b;
			reg_rd(`JFA_IR_DATA, 11, d);
			check("fail", k == 1, d[2]);
			check("byte", b, d[10:3]);
			check("extra_req", 0, req_q.size());
			reg_rd(`JFA_IR_ADDR, 17, d);
			check("addr_inc", a + 16'h1, d[16:1]);
		end
		$display("test program done");
		reg_wr(`JFA_IR_ADDR, 20, {2'b11, a0, 2'b00});
		reg_wr(`JFA_IR_CTRL, 10, {2'b11, 8'h20});
		reg_wr(`JFA_IR_DATA, 10, {2'b11, 8'h5A});
		check("erase_refused", 0, req_q.size());
		reg_wr(`JFA_IR_DATA, 10, {2'b11, `JFA_ERASE_KEY});
		exp_req(FL_ERASE, 1'b0, a0, 8'hA5);
		wait_idle();
		for (int j = 0; j < 512; j++) ref_mem[{1'b0, a0[15:9], j[8:0]}] = 8'hFF;
		reg_rd(`JFA_IR_ADDR, 17, d);
		check("erase_addr", a0, d[16:1]);
		$display("test erase done");
		reg_wr(`JFA_IR_ADDR, 20, {2'b11, a2, 2'b00});
		nxt_a = a2;
		exp_b = 8'hA5;
		reg_wr(`JFA_IR_CTRL, 10, {2'b11, 8'h82});
		rd_step(1'b1);
		rd_step(1'b0);
		rd_step(1'b1);
		reg_wr(`JFA_IR_CTRL, 10, {2'b11, 8'h81});
		rd_step(1'b1);
		rd_step(1'b1);
		$display("test read done");
		test_done();
	end
endmodule : tb_top

bind jtag_flash_access_port jfa_properties i_jfa_properties (.clk(clk), .rst_n(rst_n),
	.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .fl_valid(fl_valid),
	.fl_req(fl_req), .fl_done(fl_done), .fl_fail(fl_fail), .fl_rdata(fl_rdata),
	.cpu_halted(cpu_halted), .supervisory_timer_hold(supervisory_timer_hold),
	.periph_run(periph_run));
